// >>> hrc_cfg.svh
// Constants for the halt release controller: operand bit positions and widths.
// Assumes inclusion by bare name from every file that needs them.
`ifndef HRC_CFG_SVH
`define HRC_CFG_SVH

`define HRC_OP_W 4
`define HRC_BIT_KEY 0
`define HRC_BIT_TMR 1
`define HRC_BIT_INT 3
`define HRC_KEY_LINES 4
`define HRC_SEL_W 2
`define HRC_IRQ_N 10
`define HRC_VEC_W 4
`define HRC_OP_NONE 4'h0

`endif

// >>> hrc_pkg.sv
// Types shared by the halt release controller.
// Assumes hrc_cfg.svh supplies the widths.
`include "hrc_cfg.svh"

package hrc_pkg;

   // Processor run state
   typedef enum logic {
      HRC_RUN,
      HRC_HALT
   } hrc_state_e;

   typedef logic [`HRC_OP_W-1:0] hrc_op_t;

endpackage : hrc_pkg

// >>> hrc_key_latch.sv
// One key sense line: three-stage synchroniser and the input latch behind it.
// Assumes the pin is asynchronous to sys_clk_i; reset is synchronous.
module hrc_key_latch (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic pin_i,
   input wire logic detach_i,
   output logic latch_o,
   output logic conv_o
);

   logic sync1;
   logic sync2;
   logic sync3;
   logic latch;
   logic next_latch;

   // Latch follows an agreed pin level only while attached
   always_comb begin
      next_latch = latch;
      if (!detach_i && (sync2 == sync3)) begin
         next_latch = sync3;
      end
   end

   // Synchroniser and latch registers; detached latch keeps its level
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
         latch <= 1'b0;
      end else if (ce_i) begin
         sync1 <= pin_i;
         sync2 <= sync1;
         sync3 <= sync2;
         latch <= next_latch;
      end
   end

   assign latch_o = latch;
   assign conv_o = sync3 & detach_i; // Detached line feeds the converter

endmodule : hrc_key_latch

// >>> hrc_halt_ctrl.sv
// Halt control: gates the processor clock on a halt instruction and ends
// the halt on key, timer zero carry or accepted interrupt, or on any reset.
// Power-on reset acts always; chip-enable reset and all updates wait for ce_i.
// Assumes halt requests, timer carry and interrupt lines come from logic on
// sys_clk_i; key sense lines are pins and are synchronised here.
`include "hrc_cfg.svh"

// Operation
// - A halt instruction gates off the processor clock and stops execution while peripherals keep running.
// - The halt instruction is taken whatever the chip-enable level; the code takes it only on a cycle with ce_i high.
// - A 4-bit operand in the halt instruction enables one wake source per set bit.
// - Wake sources are key input, timer zero carry and interrupt acceptance.
// - With several sources enabled, any one satisfied ends the halt.
// - After a key or timer release the processor resumes at the instruction after the halt.
// - Power-on reset or chip-enable reset always ends the halt and resets; the code takes chip-enable reset only on a cycle with ce_i high.
// - An all-zero operand enables no source, so only a reset ends that halt.
// - Operand 0001B ends the halt when any of the four key lines latches high.
// - A key line chosen as converter input is cut from its latch, one line at a time.
// - A latch that held high before its line was cut stays high and ends a key halt at once.
// - Operand 0010B ends the halt in the same event that sets the timer zero carry flag.
// - Operand 1000B ends the halt on interrupt acceptance and branches to its vector.
// - A request lacking its own or the global enable is not accepted and does not wake.
module hrc_halt_ctrl #(
   parameter int IRQ_N = `HRC_IRQ_N,
   parameter int KEY_LINES = `HRC_KEY_LINES
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic ce_reset_i,
   input wire logic halt_req_i,
   input wire logic [`HRC_OP_W-1:0] halt_operand_i,
   input wire logic [KEY_LINES-1:0] key_sense_port_i,
   input wire logic conv_sel_en_i,
   input wire logic [`HRC_SEL_W-1:0] conv_sel_i,
   input wire logic timer_zero_carry_flag_i,
   input wire logic [IRQ_N-1:0] irq_req_i,
   input wire logic [IRQ_N-1:0] irq_en_i,
   input wire logic irq_global_en_i,
   output logic cpu_clk_en_o,
   output logic halted_o,
   output logic resume_next_o,
   output logic irq_accept_o,
   output logic [`HRC_VEC_W-1:0] irq_vector_o,
   output logic [KEY_LINES-1:0] key_latch_o,
   output logic conv_in_o
);

   hrc_pkg::hrc_state_e state;
   hrc_pkg::hrc_state_e next_state;
   hrc_pkg::hrc_op_t wake_mask;
   hrc_pkg::hrc_op_t next_wake_mask;
   logic next_cpu_clk_en;
   logic next_resume_next;
   logic next_irq_accept;
   logic [`HRC_VEC_W-1:0] next_irq_vector;
   logic [KEY_LINES-1:0] next_key_latch;
   logic next_conv_in;
   logic [KEY_LINES-1:0] latch_w;
   logic [KEY_LINES-1:0] conv_w;
   logic [KEY_LINES-1:0] detach_w;
   logic [IRQ_N-1:0] irq_ok;
   logic key_hit;
   logic irq_hit;
   logic [`HRC_VEC_W-1:0] irq_idx;
   logic wake;
   logic key_wake;
   logic tmr_wake;
   logic irq_wake;
   logic any_reset;
   logic next_halted;

   // Detach decode: at most one line selected
   // Only one line can be cut at a time, so the converter never sees two
   always_comb begin
      detach_w = '0;
      if (conv_sel_en_i) begin
         detach_w[conv_sel_i] = 1'b1;
      end
   end

   // Per-line synchroniser and input latch
   // Wake reads the internal latches; key_latch_o trails them by one cycle
   genvar g;
   generate
      for (g = 0; g < KEY_LINES; g = g + 1) begin : g_key
         hrc_key_latch u_key (
            .sys_clk_i(sys_clk_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .pin_i(key_sense_port_i[g]),
            .detach_i(detach_w[g]),
            .latch_o(latch_w[g]),
            .conv_o(conv_w[g])
         );
      end
   endgenerate

   // Interrupt acceptance: both enables needed, lowest index has priority
   // A request lacking either enable never reaches the wake OR
   always_comb begin
      irq_ok = irq_req_i & irq_en_i & {IRQ_N{irq_global_en_i}};
      irq_hit = |irq_ok;
      irq_idx = '0;
      for (int i = IRQ_N - 1; i >= 0; i--) begin
         if (irq_ok[i]) begin
            irq_idx = `HRC_VEC_W'(i);
         end
      end
   end

   // Per-source release terms, each gated by its bit of the held operand
   always_comb begin
      key_hit = |latch_w;
      key_wake = wake_mask[`HRC_BIT_KEY] & key_hit;
      tmr_wake = wake_mask[`HRC_BIT_TMR] & timer_zero_carry_flag_i;
      irq_wake = wake_mask[`HRC_BIT_INT] & irq_hit;
   end

   // Wake condition: OR of the enabled terms
   always_comb begin
      wake = key_wake | tmr_wake | irq_wake;
   end

   // Combined reset: power-on or chip-enable reset always leaves halt
   // Chip-enable reset needs a clocked cycle; power-on reset does not
   always_comb begin
      any_reset = rst_i | (ce_i & ce_reset_i);
   end

   // Next state of the halt machine
   always_comb begin
      next_state = state;
      next_wake_mask = wake_mask;
      next_cpu_clk_en = cpu_clk_en_o;
      case (state)
         hrc_pkg::HRC_RUN: begin
            // Entry is registered only on a cycle with ce_i high
            if (halt_req_i) begin
               next_state = hrc_pkg::HRC_HALT;
               next_wake_mask = halt_operand_i;
               next_cpu_clk_en = 1'b0;
            end
         end
         hrc_pkg::HRC_HALT: begin
            // Checked every cycle; clock returns the following cycle
            // A fresh halt request here is ignored
            if (wake) begin
               next_state = hrc_pkg::HRC_RUN;
               next_wake_mask = `HRC_OP_NONE;
               next_cpu_clk_en = 1'b1;
            end
         end
         default: begin
            next_state = hrc_pkg::HRC_RUN;
            next_cpu_clk_en = 1'b1;
         end
      endcase
      next_halted = (next_state == hrc_pkg::HRC_HALT);
   end

   // Halt machine registers; reset leaves halt with the clock running
   always_ff @(posedge sys_clk_i) begin
      if (any_reset) begin
         state <= hrc_pkg::HRC_RUN;
         wake_mask <= `HRC_OP_NONE;
         cpu_clk_en_o <= 1'b1;
         halted_o <= 1'b0;
      end else if (ce_i) begin
         state <= next_state;
         wake_mask <= next_wake_mask;
         cpu_clk_en_o <= next_cpu_clk_en;
         halted_o <= next_halted;
      end
   end

   // Release pulses: interrupt acceptance outranks a plain resume
   always_comb begin
      next_resume_next = 1'b0;
      next_irq_accept = 1'b0;
      next_irq_vector = irq_vector_o;
      if ((state == hrc_pkg::HRC_HALT) && wake) begin
         // Release sets exactly one of the two pulses
         if (irq_wake) begin
            next_irq_accept = 1'b1;
            next_irq_vector = irq_idx;
         end else begin
            next_resume_next = 1'b1;
         end
      end
   end

   // Release pulse registers; a pulse stands for one clocked cycle
   always_ff @(posedge sys_clk_i) begin
      if (any_reset) begin
         resume_next_o <= 1'b0;
         irq_accept_o <= 1'b0;
         irq_vector_o <= '0;
      end else if (ce_i) begin
         resume_next_o <= next_resume_next;
         irq_accept_o <= next_irq_accept;
         irq_vector_o <= next_irq_vector;
      end
   end

   // Key mirror: latch contents and the detached line's level
   always_comb begin
      next_key_latch = latch_w;
      next_conv_in = |conv_w;
   end

   // Key mirror registers
   always_ff @(posedge sys_clk_i) begin
      if (any_reset) begin
         key_latch_o <= '0;
         conv_in_o <= 1'b0;
      end else if (ce_i) begin
         key_latch_o <= next_key_latch;
         conv_in_o <= next_conv_in;
      end
   end

endmodule : hrc_halt_ctrl

// >>> hrc_halt_asserts.sv
// Checker of halt entry and release at the controller ports.
// Assumes one clock domain and a synchronous active-high reset.
module hrc_halt_asserts #(parameter int IRQ_N = 10, parameter int KEY_LINES = 4) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic ce_reset_i,
   input wire logic halt_req_i,
   input wire logic [3:0] halt_operand_i,
   input wire logic timer_zero_carry_flag_i,
   input wire logic [IRQ_N-1:0] irq_req_i,
   input wire logic [IRQ_N-1:0] irq_en_i,
   input wire logic irq_global_en_i,
   input wire logic cpu_clk_en_o,
   input wire logic halted_o,
   input wire logic resume_next_o,
   input wire logic irq_accept_o,
   input wire logic [KEY_LINES-1:0] key_latch_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] op_q;
   logic hold;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // Operand of the halt in force
   always_ff @(posedge sys_clk_i) begin
      if (halt_req_i && !halted_o && ce_i) op_q <= halt_operand_i;
   end
   // Halted, clocked and not being reset
   assign hold = ce_i && !ce_reset_i && halted_o;
   sequence s_release;
      !halted_o && cpu_clk_en_o;
   endsequence
   chk_halt_entry: assert property (halt_req_i && !halted_o && ce_i && !ce_reset_i
      |=> halted_o && !cpu_clk_en_o) else $error("halt not entered");
   chk_zero_stay: assert property (hold && op_q == 4'h0
      |=> halted_o) else $error("empty operand woke");
   chk_ce_reset: assert property (ce_reset_i && ce_i
      |=> s_release) else $error("reset kept halt");
   chk_timer_wake: assert property (hold && op_q[1] && timer_zero_carry_flag_i
      |=> s_release) else $error("carry did not wake");
   chk_irq_wake: assert property (hold && op_q[3] && irq_global_en_i && |(irq_req_i & irq_en_i)
      |=> s_release ##0 irq_accept_o) else $error("interrupt did not wake");
   chk_irq_masked: assert property (hold && op_q == 4'h8 && !irq_global_en_i
      |=> halted_o) else $error("masked interrupt woke");
   chk_key_wake: assert property (hold && op_q[0] && |key_latch_o
      |-> ##[0:2] s_release) else $error("key did not wake");
   chk_resume_pulse: assert property (resume_next_o
      |-> $past(halted_o) ##1 !resume_next_o) else $error("bad resume pulse");
endmodule : hrc_halt_asserts

bind hrc_halt_ctrl hrc_halt_asserts #(.IRQ_N(IRQ_N), .KEY_LINES(KEY_LINES)) u_chk (.sys_clk_i,
   .rst_i, .ce_i, .ce_reset_i, .halt_req_i, .halt_operand_i, .timer_zero_carry_flag_i, .irq_req_i,
   .irq_en_i, .irq_global_en_i, .cpu_clk_en_o, .halted_o, .resume_next_o, .irq_accept_o, .key_latch_o);

// >>> hrc_core_model.sv
// Processor core model: issues halt instructions with a release operand.
// Assumes the bench calls issue() and inputs move at the falling edge.
module hrc_core_model (
   input wire logic sys_clk_i,
   output logic halt_req_o,
   output logic [3:0] halt_operand_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      halt_req_o = 1'b0;
      halt_operand_o = 4'h0;
   end
   // One-cycle halt instruction; operand scrambled once dropped
   task automatic issue(input logic [3:0] op);
      @(negedge sys_clk_i);
      halt_req_o = 1'b1;
      halt_operand_o = op;
      @(negedge sys_clk_i);
      halt_req_o = 1'b0;
      halt_operand_o = ~op;
   endtask : issue
endmodule : hrc_core_model

// >>> test_cpu_halt_release_control.sv
// Bench for the halt controller: core model, key, timer and interrupt stimulus.
// Assumes the checker is bound to the controller.
module test_cpu_halt_release_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, ce_reset_i = 1'b0, conv_sel_en_i = 1'b0;
   logic timer_zero_carry_flag_i = 1'b0, irq_global_en_i = 1'b0, halt_req_i;
   logic [3:0] key_sense_port_i = 4'h0, halt_operand_i, irq_vector_o, key_latch_o;
   logic [1:0] conv_sel_i = 2'h0;
   logic [9:0] irq_req_i = 10'h000, irq_en_i = 10'h0c0;
   logic cpu_clk_en_o, halted_o, resume_next_o, irq_accept_o, conv_in_o;
   int error_cnt = 0, n_compared = 0;
`define CMP(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
   initial forever #2.5 sys_clk_i = ~sys_clk_i;
   hrc_halt_ctrl u_dut (.sys_clk_i, .rst_i, .ce_i, .ce_reset_i, .halt_req_i, .halt_operand_i,
      .key_sense_port_i, .conv_sel_en_i, .conv_sel_i, .timer_zero_carry_flag_i, .irq_req_i,
      .irq_en_i, .irq_global_en_i, .cpu_clk_en_o, .halted_o, .resume_next_o, .irq_accept_o,
      .irq_vector_o, .key_latch_o, .conv_in_o);
   hrc_core_model u_core (.sys_clk_i, .halt_req_o(halt_req_i), .halt_operand_o(halt_operand_i));
   task automatic stop_test;
      $display("compared %0d mismatched %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask : cyc
   // Bounded wait for the halt flag to reach a level
   task automatic wt(input logic v);
      int i;
      for (i = 0; i < 20 && halted_o !== v; i++) @(negedge sys_clk_i);
      if (i == 20) begin
         error_cnt++;
         stop_test();
      end
   endtask : wt
   // Empty operand ignores timer carry and interrupt; chip-enable reset ends it
   task automatic t_zero;
      u_core.issue(4'h0);
      {timer_zero_carry_flag_i, irq_global_en_i, irq_req_i} = {2'h3, 10'h0c0};
      cyc(1);
      {timer_zero_carry_flag_i, irq_global_en_i, irq_req_i} = 12'h000;
      cyc(3);
      `CMP(halted_o, 1'b1)
      ce_reset_i = 1'b1;
      cyc(1);
      ce_reset_i = 1'b0;
      `CMP(cpu_clk_en_o, 1'b1)
      `CMP(halted_o, 1'b0)
      u_core.issue(4'h0);
      cyc(1);
      `CMP(halted_o, 1'b1)
      rst_i = 1'b1;
      cyc(1);
      rst_i = 1'b0;
      `CMP({halted_o, cpu_clk_en_o}, 2'h1)
      $display("zero done");
   endtask : t_zero
   // Timer carry wake, then all sources with masked interrupts
   task automatic t_timer(input logic [3:0] op);
      u_core.issue(op);
      {irq_global_en_i, irq_req_i} = {1'b1, 10'h300};
      cyc(2);
      `CMP(cpu_clk_en_o, 1'b0)
      timer_zero_carry_flag_i = 1'b1;
      cyc(1);
      {timer_zero_carry_flag_i, irq_global_en_i, irq_req_i} = 12'h000;
      `CMP(resume_next_o, 1'b1)
      $display("timer done");
   endtask : t_timer
   // Interrupt wake needs the global enable; lowest pending index wins
   task automatic t_irq;
      irq_req_i = 10'h0c0;
      u_core.issue(4'h8);
      cyc(3);
      `CMP(halted_o, 1'b1)
      irq_global_en_i = 1'b1;
      wt(1'b0);
      `CMP({irq_accept_o, irq_vector_o}, 5'h16)
      {irq_global_en_i, irq_req_i} = 11'h000;
      $display("irq done");
   endtask : t_irq
   // Key wake, then a detached line whose latch held high
   task automatic t_key;
      u_core.issue(4'h1);
      cyc(3);
      `CMP(halted_o, 1'b1)
      key_sense_port_i = 4'h4;
      wt(1'b0);
      `CMP(resume_next_o, 1'b1)
      cyc(4);
      {conv_sel_en_i, conv_sel_i, key_sense_port_i} = 7'h64;
      cyc(6);
      `CMP({key_latch_o, conv_in_o}, 5'h09)
      key_sense_port_i = 4'h0;
      cyc(6);
      `CMP({key_latch_o, conv_in_o}, 5'h08)
      u_core.issue(4'h1);
      cyc(1);
      `CMP(halted_o, 1'b0)
      `CMP(resume_next_o, 1'b1)
      $display("key done");
   endtask : t_key
   initial begin
      cyc(16);
      rst_i = 1'b0;
      t_zero();
      t_timer(4'h2);
      t_timer(4'hb);
      t_irq();
      t_key();
      stop_test();
   end
endmodule : test_cpu_halt_release_control
